// *** verilog/serial_receive_status_control.sv ***
// Receive status and control register with its accept and error logic
// Behaviour
// R01: Setting serial_port_on hands rx_data_pin and tx_clock_pin to the port.
// R02: Clearing serial_port_on disables the port and releases its pins.
// R03: rx_nine_bit_select picks 9-bit reception when set, 8-bit when clear.
// R04: In sync master mode single_rx_enable runs one reception, then clears.
// R05: single_rx_enable has no effect in async mode or sync slave mode.
// R06: continuous_rx_enable enables successive reception in every mode.
// R07: Async 9-bit address detect loads only characters with bit 8 set.
// R08: Without address detect every received character is accepted.
// R09: framing_error_flag tracks the current character, updated on each load.
// R10: Overrun sets overrun_error_flag; only clearing cont receive clears it. The flag never sets while cont is clear (single receive).
// R11: Bits 7..3 read-write reset 0; bits 2..0 are read-only status.
//
// The implementer's own choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`include "rx_status_map.svh"
module serial_receive_status_control
(
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // Wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [3:0] wb_adr_in,
  input wire logic [7:0] wb_dat_in,
  input wire logic wb_sel_in,
  output logic [7:0] wb_dat_out,
  output logic wb_ack_out,
  // Mode from the transmit side
  input rx_status_pkg::rx_mode_t mode_in,
  // Receive shift register side
  input rx_status_pkg::rx_char_t rx_char_in,
  input wire logic buffer_read_in,
  input wire logic buffer_full_in,
  // Towards the datapath and pins
  output logic pins_to_port_out,
  output logic rx_enable_out,
  output logic nine_bit_out,
  output logic load_buffer_out,
  output logic rx_irq_request_out
);
  import rx_status_pkg::*;

  rsc_state_t st;
  rsc_state_t next_st;
  logic port_on;
  logic nine;
  logic single;
  logic cont;
  logic addr_det;
  logic single_active;
  logic accept;
  logic wr;
  logic rd_sel;

  // Every check below runs on the one clock and rests during reset
  default clocking chk_cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  // ********************************************************************
  // Field decode
  // ********************************************************************
  assign port_on = st.ctrl[`RSC_BIT_PORT_ON-`RSC_CTRL_LSB];
  assign nine = st.ctrl[`RSC_BIT_NINE-`RSC_CTRL_LSB];
  assign single = st.ctrl[`RSC_BIT_SINGLE-`RSC_CTRL_LSB];
  assign cont = st.ctrl[`RSC_BIT_CONT-`RSC_CTRL_LSB];
  assign addr_det = st.ctrl[`RSC_BIT_ADDR_DET-`RSC_CTRL_LSB];

  // Single receive only counts for a synchronous master
  assign single_active = single && mode_in.sync_mode
    && mode_in.sync_master; // see R04 see R05

  assign rd_sel = wb_adr_in == `RSC_ADDR;
  // The write lands at the edge where the master sees ack high
  assign wr = wb_cyc_in && wb_stb_in && st.ack && wb_we_in
    && wb_sel_in && rd_sel;

  // Address detect filters only in async 9-bit mode
  assign accept = rx_char_in.done && port_on && rx_enable_out
    && (!(addr_det && nine && !mode_in.sync_mode)
    || rx_char_in.data[`RSC_NINTH_DATA_BIT]); // see R07 see R08

  // ********************************************************************
  // Next state
  // ********************************************************************
  always_comb
  begin
    next_st = st;
    next_st.ack = wb_cyc_in && wb_stb_in && !st.ack;
    next_st.rdata = rd_sel ? {st.ctrl, st.framing_error_flag,
      st.overrun_error_flag, st.rx_ninth_bit} : `RSC_ZERO8;
    if (wr)
    begin
      next_st.ctrl = wb_dat_in[`RSC_BIT_PORT_ON:`RSC_CTRL_LSB]; // see R11
    end
    // Completion of a single reception clears the request bit
    if (rx_char_in.done && single_active)
    begin
      next_st.ctrl[`RSC_BIT_SINGLE-`RSC_CTRL_LSB] = 1'b0; // see R04
    end
    // Flags load only with an accepted character
    if (accept && !buffer_full_in)
    begin
      next_st.framing_error_flag = rx_char_in.frame_err; // see R09
      next_st.rx_ninth_bit = nine
        ? rx_char_in.data[`RSC_NINTH_DATA_BIT] : 1'b0; // see R03
    end
    // Clearing continuous receive is the only clear; a new overrun
    // in that cycle is dropped because reception is already stopping
    if (!next_st.ctrl[`RSC_BIT_CONT-`RSC_CTRL_LSB])
    begin
      next_st.overrun_error_flag = 1'b0; // see R10
    end
    else if (accept && buffer_full_in && !buffer_read_in)
    begin
      next_st.overrun_error_flag = 1'b1; // see R10
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      st <= '0;
      st.ctrl <= `RSC_CTRL_RESET; // see R11
    end
    else if (ce_in)
    begin
      st <= next_st;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  assign wb_ack_out = st.ack;
  assign wb_dat_out = st.rdata;
  assign pins_to_port_out = port_on; // see R01 see R02
  assign rx_enable_out = port_on && (cont || single_active); // see R06
  assign nine_bit_out = nine; // see R03
  assign load_buffer_out = accept && !buffer_full_in && rx_enable_out;
  assign rx_irq_request_out = load_buffer_out; // see R07

  // ********************************************************************
  // Bus and state checks
  // ********************************************************************
  a_ack_pulse: assert property
    (wb_ack_out |=> !wb_ack_out)
    else $error("ack held for more than one cycle");

  a_ack_answer: assert property
    ((ce_in && wb_cyc_in && wb_stb_in && !wb_ack_out) |=> wb_ack_out)
    else $error("request not answered in one cycle");

  a_idle_no_ack: assert property
    ((ce_in && !(wb_cyc_in && wb_stb_in)) |=> !wb_ack_out)
    else $error("ack without a request");

  a_unmapped_zero: assert property // see R11
    ((ce_in && !rd_sel) |=> wb_dat_out == `RSC_ZERO8)
    else $error("unmapped address read not zero");

  a_read_image: assert property // see R11
    ((ce_in && rd_sel) |=> wb_dat_out == $past({st.ctrl,
    st.framing_error_flag, st.overrun_error_flag, st.rx_ninth_bit}))
    else $error("read data does not match the register");

  a_write_lands: assert property // see R11
    ((ce_in && wr && !(rx_char_in.done && single_active)) |=>
    st.ctrl == $past(wb_dat_in[`RSC_BIT_PORT_ON:`RSC_CTRL_LSB]))
    else $error("write to control bits lost");

  a_no_sel_write: assert property // see R11
    ((ce_in && !wb_sel_in && !rx_char_in.done) |=>
    st.ctrl == $past(st.ctrl))
    else $error("control bits changed without byte select");

  a_ce_freeze: assert property
    (!ce_in |=> st == $past(st))
    else $error("state moved with clock enable low");

  a_reset_state: assert property // see R11
    ($fell(rst_in) |-> st.ctrl == `RSC_CTRL_RESET && !wb_ack_out
    && !st.overrun_error_flag && !st.framing_error_flag)
    else $error("register not cleared by reset");

  // ********************************************************************
  // Control checks
  // ********************************************************************
  a_pins_follow: assert property // see R01
    ((ce_in && wr) |=>
    pins_to_port_out == $past(wb_dat_in[`RSC_BIT_PORT_ON]))
    else $error("pin ownership does not follow port enable");

  a_port_off: assert property // see R02
    (!port_on |-> !rx_enable_out && !load_buffer_out)
    else $error("disabled port still receives");

  a_nine_follow: assert property // see R03
    ((ce_in && wr) |=> nine_bit_out == $past(wb_dat_in[`RSC_BIT_NINE]))
    else $error("width select does not follow its bit");

  a_single_clear: assert property // see R04
    ((ce_in && rx_char_in.done && single_active && !wr)
    |=> !single)
    else $error("single receive not cleared after completion");

  a_single_starts: assert property // see R04
    ((port_on && single && mode_in.sync_mode && mode_in.sync_master)
    |-> rx_enable_out)
    else $error("single receive did not enable reception");

  a_single_ignored: assert property // see R05
    ((single && !cont && !mode_in.sync_master) |-> !rx_enable_out)
    else $error("single receive acted outside sync master");

  a_cont_enables: assert property // see R06
    ((port_on && cont) |-> rx_enable_out)
    else $error("continuous receive not enabled");

  // ********************************************************************
  // Receive checks
  // ********************************************************************
  a_addr_filter: assert property // see R07
    ((load_buffer_out && addr_det && nine && !mode_in.sync_mode)
    |-> rx_char_in.data[`RSC_NINTH_DATA_BIT])
    else $error("address detect let a data character through");

  a_accept_all: assert property // see R08
    ((rx_char_in.done && rx_enable_out && !addr_det) |-> accept)
    else $error("character refused without address detect");

  a_framing_error_flag_load: assert property // see R09
    ((ce_in && accept && !buffer_full_in) |=>
    st.framing_error_flag == $past(rx_char_in.frame_err))
    else $error("framing flag not loaded with character");

  a_framing_error_flag_hold: assert property // see R09
    ((ce_in && !(accept && !buffer_full_in)) |=>
    $stable(st.framing_error_flag))
    else $error("framing flag moved without a load");

  a_ninth_load: assert property // see R03
    ((ce_in && accept && !buffer_full_in) |=> st.rx_ninth_bit ==
    ($past(nine) && $past(rx_char_in.data[`RSC_NINTH_DATA_BIT])))
    else $error("ninth bit not loaded with character");

  a_overrun_error_flag_set: assert property // see R10
    ((ce_in && accept && buffer_full_in && !buffer_read_in
    && next_st.ctrl[`RSC_BIT_CONT-`RSC_CTRL_LSB]) |=> st.overrun_error_flag)
    else $error("overrun not flagged");

  a_overrun_error_flag_clear: assert property // see R10
    ((ce_in && !next_st.ctrl[`RSC_BIT_CONT-`RSC_CTRL_LSB]) |=>
    !st.overrun_error_flag)
    else $error("overrun flag survived clearing continuous receive");

  a_overrun_error_flag_hold: assert property // see R10
    ((ce_in && !st.overrun_error_flag
    && !(accept && buffer_full_in && !buffer_read_in)) |=>
    !st.overrun_error_flag)
    else $error("overrun flag set without an overrun");

  a_ro_bits: assert property // see R11
    ((ce_in && wr && !accept) |=> st.framing_error_flag ==
    $past(st.framing_error_flag))
    else $error("write changed a read-only flag");

  c_overrun: cover property
    (!st.overrun_error_flag ##1 st.overrun_error_flag);
  c_single_done: cover property
    (single_active ##1 !single);
  c_addr_drop: cover property
    (rx_char_in.done && port_on && !accept);
  c_load: cover property
    (load_buffer_out);
  c_framing_error_flag_seen: cover property
    (!st.framing_error_flag ##1 st.framing_error_flag);
endmodule

// *** verilog/rx_status_map.svh ***
// Register offsets, field positions and reset values of the receive status
`ifndef RX_STATUS_MAP_SVH
`define RX_STATUS_MAP_SVH
`define RSC_ADDR 4'h0
`define RSC_BIT_PORT_ON 7
`define RSC_BIT_NINE 6
`define RSC_BIT_SINGLE 5
`define RSC_BIT_CONT 4
`define RSC_BIT_ADDR_DET 3
`define RSC_BIT_FRAMING_ERROR_FLAG 2
`define RSC_BIT_OVERRUN_ERROR_FLAG 1
`define RSC_BIT_NINTH 0
`define RSC_CTRL_LSB 3
`define RSC_NINTH_DATA_BIT 8
`define RSC_CTRL_RESET 5'h00
`define RSC_ZERO8 8'h00
`endif

// *** verilog/rx_status_pkg.sv ***
// Types shared by the receive status and control block
package rx_status_pkg;
  typedef struct packed
  {
    logic [4:0] ctrl;
    logic framing_error_flag;
    logic overrun_error_flag;
    logic rx_ninth_bit;
    logic [7:0] rdata;
    logic ack;
  } rsc_state_t;

  typedef struct packed
  {
    logic done;
    logic [8:0] data;
    logic frame_err;
  } rx_char_t;

  typedef struct packed
  {
    logic sync_mode;
    logic sync_master;
  } rx_mode_t;
endpackage

// *** tb/rx_peer.sv ***
// Serial peer model: hands finished characters to the receive side
`timescale 1ns/1ps
module rx_peer
  import rx_status_pkg::*;
(
  // Clock
  input wire logic clk_in,
  // Request from the bench: {ninth, data, frame error}
  input wire logic send_in,
  input wire logic [9:0] char_in,
  // Towards the receive side
  output rx_char_t rx_char_out
);
  initial rx_char_out = '0;
  // Between characters the lines toggle so no stale value looks valid
  always @(posedge clk_in)
  begin
    rx_char_out.done <= send_in;
    rx_char_out.data <= send_in ? char_in[9:1] : ~rx_char_out.data;
    rx_char_out.frame_err <= send_in ? char_in[0] : ~rx_char_out.frame_err;
  end
endmodule

// *** tb/serial_receive_status_control_tb.sv ***
// Self-checking bench for the receive status and control register
`timescale 1ns/1ps
module serial_receive_status_control_tb;
  import rx_status_pkg::*;
  logic clk_in = 0, rst_in = 1, cyc = 0, we = 0, send = 0, rd_buf = 0;
  logic full = 0, ef = 0, en9 = 0, ack, pins, rxen, nine, load, irq;
  logic [3:0] adr = 4'h0;
  logic [7:0] wdat = 8'h00, ctl = 8'h00, dat_o, rdat;
  logic [9:0] chr = 10'h000, rnd = 10'h000;
  rx_mode_t mode = '0;
  rx_char_t rxc;
  integer err_total = 0, samples_checked = 0, seed = 89985;
  serial_receive_status_control dut (.clk_in(clk_in), .rst_in(rst_in),
    .ce_in(1'b1), .wb_cyc_in(cyc), .wb_stb_in(cyc), .wb_we_in(we),
    .wb_adr_in(adr), .wb_dat_in(wdat), .wb_sel_in(1'b1), .wb_dat_out(dat_o),
    .wb_ack_out(ack), .mode_in(mode), .rx_char_in(rxc),
    .buffer_read_in(rd_buf), .buffer_full_in(full), .pins_to_port_out(pins),
    .rx_enable_out(rxen), .nine_bit_out(nine), .load_buffer_out(load),
    .rx_irq_request_out(irq));
  rx_peer peer (.clk_in(clk_in), .send_in(send), .char_in(chr),
    .rx_char_out(rxc));
  initial
  begin
    forever #20 clk_in = ~clk_in;
  end
  // About forty times the expected run length
  initial
  begin
    #200000;
    err_total++;
    wrap_up();
  end
  function automatic logic acc(input logic [9:0] c);
    return (!(ctl[3] && ctl[6] && !mode.sync_mode) || c[9]) && !full;
  endfunction
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] d, input logic [3:0] a);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_in);
    while (ack !== 1'b1) @(posedge clk_in);
    rdat = dat_o;
    cyc <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic put(input logic [9:0] c);
    send <= 1'b1;
    chr <= c;
    @(posedge clk_in);
    send <= 1'b0;
    #1;
    chk("load", {7'h00, acc(c)}, {7'h00, load});
    chk("irq", {7'h00, acc(c)}, {7'h00, irq});
    if (acc(c))
    begin
      ef = c[0];
      en9 = c[9] & ctl[6];
    end
    @(posedge clk_in);
    bus(1'b0, 8'h00, 4'h0);
  endtask
  task automatic wrap_up();
    if (err_total == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    bus(1'b0, 8'h00, 4'h0);
    chk("reset", 8'h00, rdat);
    bus(1'b1, 8'hff, 4'h0);
    bus(1'b0, 8'h00, 4'h0);
    chk("rw", 8'hf8, rdat);
    chk("outs", 8'he0, {pins, nine, rxen, 5'h00});
    bus(1'b1, 8'h55, 4'h3);
    bus(1'b0, 8'h00, 4'h3);
    chk("unmapped", 8'h00, rdat);
    bus(1'b1, 8'h00, 4'h0);
    chk("outs", 8'h00, {pins, nine, rxen, 5'h00});
    for (int i = 0; i < 12; i++)
    begin
      ctl = (i < 6) ? 8'hd8 : 8'hd0;
      if (i % 6 == 0) bus(1'b1, ctl, 4'h0);
      rnd = 10'($random(seed));
      if (i < 2) rnd[9] = i[0];
      put(rnd);
      chk("status", {ctl[7:3], ef, 1'b0, en9}, rdat);
    end
    full <= 1'b1;
    rd_buf <= 1'b1;
    put(10'h3fe);
    chk("noover", {ctl[7:3], ef, 1'b0, en9}, rdat);
    rd_buf <= 1'b0;
    put(10'h3fe);
    chk("overrun", {ctl[7:3], ef, 1'b1, en9}, rdat);
    full <= 1'b0;
    put(10'h001);
    chk("sticky", {ctl[7:3], ef, 1'b1, en9}, rdat);
    ctl = 8'hc0;
    bus(1'b1, ctl, 4'h0);
    bus(1'b0, 8'h00, 4'h0);
    chk("oclear", {ctl[7:3], ef, 1'b0, en9}, rdat);
    mode <= 2'b11;
    ctl = 8'ha0;
    bus(1'b1, ctl, 4'h0);
    chk("master", 8'h01, {7'h00, rxen});
    put(10'h154);
    chk("single", {5'h10, ef, 1'b0, en9}, rdat);
    mode <= 2'b10;
    bus(1'b1, ctl, 4'h0);
    chk("slave", 8'h00, {7'h00, rxen});
    mode <= 2'b00;
    @(posedge clk_in);
    #1;
    chk("async", 8'h00, {7'h00, rxen});
    wrap_up();
  end
endmodule
